/* File: rtl/ewic_consts.svh */
// Constants for the external bus wait and idle-cycle controller
`ifndef EWIC_CONSTS_SVH
`define EWIC_CONSTS_SVH

`define EW_HTRANS_ACT_BIT 1
`define EW_DEC_W 8
`define EW_WCR_BASE 8'h00
`define EW_BCR_BASE 8'h40
`define EW_STAT_OFF 8'h80
`define EW_WCR_RESET 32'h0000_0500
`define EW_WCR_MASK_NORM 32'h0017_1FC3
`define EW_WCR_MASK_OTHER 32'h0000_03FF
`define EW_BCR_RESET 32'h0022_2220
`define EW_BCR_MASK 32'h0077_7777
`define EW_WCR_BYTE_SEL 20
`define EW_WCR_WRITE_WAIT_LSB 16
`define EW_WCR_WR_LSB 7
`define EW_WCR_EXT_WAIT_MASK 6
`define EW_BCR_TYPE_LSB 0
`define EW_BCR_IDLE_WRITES_LSB 4
`define EW_BCR_IDLE_RW_DIFF_LSB 8
`define EW_BCR_IDLE_RW_SAME_LSB 12
`define EW_BCR_IDLE_RR_DIFF_LSB 16
`define EW_BCR_IDLE_RR_SAME_LSB 20
`define EW_TYPE_NORMAL 3'h0
`define EW_TYPE_BSRAM 3'h1
`define EW_TYPE_SDRAM 3'h2
`define EW_TYPE_MUXIO 3'h3
`define EW_IDLE_ONE 4'h1
`define EW_IDLE_TWO 4'h2
`define EW_IDLE_FORGET 4'h8

`endif

/* File: rtl/ewic_pkg.sv */
// Types shared by the wait and idle-cycle controller
package ewic_pkg;

    // Kind of an access as seen by the idle-cycle rules
    typedef enum logic [2:0] {
        K_NONE,
        K_NORMAL_WDIS,
        K_NORMAL_WEN,
        K_BSRAM0,
        K_BSRAM1,
        K_SDRAM,
        K_MUXIO
    } ewic_kind_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_GAP,
        ST_SETUP,
        ST_STROBE,
        ST_HOLD
    } ewic_state_t;

endpackage

/* File: rtl/ewic_idle_calc.sv */
// Minimum idle cycles between the previous and the next external access
`timescale 1ns/1ps
`include "ewic_consts.svh"
module ewic_idle_calc import ewic_pkg::*; (
    // Previous access
    input wire ewic_kind_t prev_kind,
    input wire logic prev_write,
    input wire logic prev_same_area,
    input wire logic [31:0] prev_bcr,
    // Next access
    input wire ewic_kind_t next_kind,
    input wire logic next_write,
    // Result
    output logic [3:0] idle_need
);

    function automatic logic [3:0] max2(input logic [3:0] a, input logic [3:0] b);
        return (a > b) ? a : b;
    endfunction

    function automatic logic [3:0] fld(input logic [31:0] v, input int lsb);
        return {1'b0, v[lsb +: 3]};
    endfunction

    always_comb begin
        logic [3:0] n;
        n = 4'h0;
        if (prev_kind != K_NONE) begin
            // Field taken from the area just accessed
            if (prev_write && next_write) begin
                n = fld(prev_bcr, `EW_BCR_IDLE_WRITES_LSB);
            end else if (prev_write != next_write) begin
                n = prev_same_area ? fld(prev_bcr, `EW_BCR_IDLE_RW_SAME_LSB)
                                   : fld(prev_bcr, `EW_BCR_IDLE_RW_DIFF_LSB);
            end else begin
                n = prev_same_area ? fld(prev_bcr, `EW_BCR_IDLE_RR_SAME_LSB)
                                   : fld(prev_bcr, `EW_BCR_IDLE_RR_DIFF_LSB);
            end
        end
        // Fixed requirements merge by maximum, never summed
        if (prev_kind == K_SDRAM && prev_write && next_kind != K_SDRAM) begin
            n = max2(n, `EW_IDLE_ONE);
        end
        if (next_kind == K_SDRAM && (prev_kind == K_NORMAL_WDIS || prev_kind == K_BSRAM0)) begin
            n = max2(n, `EW_IDLE_ONE);
        end
        if (next_kind == K_SDRAM && prev_kind == K_MUXIO) begin
            n = max2(n, `EW_IDLE_ONE);
        end
        if (next_kind == K_MUXIO) begin
            if (prev_kind == K_NONE) begin
                n = max2(n, `EW_IDLE_TWO);
            end
            if (!prev_write && (prev_kind == K_NORMAL_WDIS || prev_kind == K_NORMAL_WEN ||
                                prev_kind == K_BSRAM0 || prev_kind == K_SDRAM)) begin
                n = max2(n, `EW_IDLE_ONE);
            end
            if (prev_kind == K_SDRAM && prev_write) begin
                n = max2(n, `EW_IDLE_TWO);
            end
        end
        idle_need = n;
    end

endmodule // ewic_idle_calc

/* File: rtl/ewic_strobe_gen.sv */
// Byte write strobe, read strobe and direction timing per access phase
`timescale 1ns/1ps
module ewic_strobe_gen import ewic_pkg::*; (
    // Access in progress
    input wire ewic_state_t phase,
    input wire ewic_kind_t kind,
    input wire logic write,
    input wire logic [3:0] be,
    // Pin levels
    output logic [3:0] we_n,
    output logic rd_n,
    output logic rw_dir
);

    always_comb begin
        logic active;
        logic strobe;
        active = (phase == ST_SETUP) || (phase == ST_STROBE) || (phase == ST_HOLD);
        strobe = (phase == ST_STROBE);
        we_n = 4'hF;
        rd_n = !(strobe && !write);
        rw_dir = active && write;
        unique case (kind)
            K_BSRAM0: begin
                // Byte selects double as read enables on byte SRAM
                we_n = strobe ? ~be : 4'hF;
                rw_dir = active && write;
            end
            K_BSRAM1: begin
                we_n = active ? ~be : 4'hF;
                rw_dir = strobe && write;
            end
            default: begin
                we_n = (strobe && write) ? ~be : 4'hF;
            end
        endcase
    end

endmodule // ewic_strobe_gen

/* File: rtl/ewic_top.sv */
// External bus wait and idle-cycle controller with AHB-Lite register slave
//
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "ewic_consts.svh"
module ewic_top import ewic_pkg::*; #(
    parameter int NUM_AREAS = 9,
    parameter int AREA_W = 4,
    parameter int ADDR_W = 24
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Internal access request
    input wire logic req_valid,
    input wire logic [AREA_W-1:0] req_area,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic req_write,
    input wire logic [3:0] req_be,
    input wire logic [31:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [31:0] rsp_rdata,
    // External bus pins
    output logic [NUM_AREAS-1:0] ext_cs_n,
    output logic [ADDR_W-1:0] ext_addr,
    output logic ext_rd_n,
    output logic [3:0] byte_write_strobe_n,
    output logic read_write_direction,
    input wire logic [31:0] ext_data_in,
    output logic [31:0] ext_data_out,
    output logic ext_data_oe
);

    typedef struct packed {
        logic hready;
        logic [31:0] hrdata;
        logic dp_wr;
        logic [`EW_DEC_W-1:0] dp_addr;
        logic [NUM_AREAS-1:0][31:0] wcr;
        logic [NUM_AREAS-1:0][31:0] bcr;
        ewic_state_t st;
        logic [3:0] cnt;
        logic [3:0] elapsed;
        ewic_kind_t prev_kind;
        logic prev_write;
        logic [AREA_W-1:0] prev_area;
        ewic_kind_t cur_kind;
        logic cur_write;
        logic [AREA_W-1:0] cur_area;
        logic [3:0] cur_be;
        logic [ADDR_W-1:0] cur_addr;
        logic [31:0] cur_wdata;
        logic req_ready;
        logic rsp_valid;
        logic [31:0] rsp_rdata;
        logic [NUM_AREAS-1:0] cs_n;
        logic rd_n;
        logic [3:0] we_n;
        logic rw_dir;
        logic [ADDR_W-1:0] addr_o;
        logic [31:0] dout;
        logic doe;
    } ewic_regs_t;

    function automatic ewic_regs_t reset_value();
        ewic_regs_t v;
        v = '0;
        v.hready = 1'b1;
        for (int i = 0; i < NUM_AREAS; i++) begin
            v.wcr[i] = `EW_WCR_RESET;
            v.bcr[i] = `EW_BCR_RESET;
        end
        v.st = ST_IDLE;
        v.prev_kind = K_NONE;
        v.cur_kind = K_NONE;
        v.cs_n = '1;
        v.rd_n = 1'b1;
        v.we_n = 4'hF;
        return v;
    endfunction

    localparam ewic_regs_t RST_V = reset_value();

    // Register slot decode: bit AREA_W is the hit, low bits the area index
    function automatic logic [AREA_W:0] slot(input logic [`EW_DEC_W-1:0] a,
                                             input logic [`EW_DEC_W-1:0] base);
        logic [`EW_DEC_W-1:0] off;
        off = a - base;
        if (a >= base && a[1:0] == 2'b00 && off[`EW_DEC_W-1:2] < NUM_AREAS) begin
            return {1'b1, off[AREA_W+1:2]};
        end
        return '0;
    endfunction

    // Writable layout follows the area's memory type
    function automatic logic [31:0] wcr_mask(input logic [31:0] bcr);
        logic [2:0] t;
        t = bcr[`EW_BCR_TYPE_LSB +: 3];
        if (t == `EW_TYPE_NORMAL || t == `EW_TYPE_BSRAM) begin
            return `EW_WCR_MASK_NORM;
        end
        return `EW_WCR_MASK_OTHER;
    endfunction

    function automatic ewic_kind_t kind_of(input logic [31:0] bcr, input logic [31:0] wcr);
        unique case (bcr[`EW_BCR_TYPE_LSB +: 3])
            `EW_TYPE_BSRAM: return wcr[`EW_WCR_BYTE_SEL] ? K_BSRAM1 : K_BSRAM0;
            `EW_TYPE_SDRAM: return K_SDRAM;
            `EW_TYPE_MUXIO: return K_MUXIO;
            default: return wcr[`EW_WCR_EXT_WAIT_MASK] ? K_NORMAL_WDIS : K_NORMAL_WEN;
        endcase
    endfunction

    ewic_regs_t r;
    ewic_regs_t n;
    logic [AREA_W-1:0] area_sel;
    logic [3:0] idle_need;
    logic [3:0] pin_we_n;
    logic pin_rd_n;
    logic pin_rw_dir;

    // Out-of-range area numbers fall back to area 0 rather than index past the array
    assign area_sel = (req_area < NUM_AREAS) ? req_area : '0;

    ewic_idle_calc u_idle (
        .prev_kind(r.prev_kind),
        .prev_write(r.prev_write),
        .prev_same_area(r.prev_area == area_sel),
        .prev_bcr(r.bcr[r.prev_area]),
        .next_kind(kind_of(r.bcr[area_sel], r.wcr[area_sel])),
        .next_write(req_write),
        .idle_need(idle_need)
    );

    ewic_strobe_gen u_strobe (
        .phase(r.st),
        .kind(r.cur_kind),
        .write(r.cur_write),
        .be(r.cur_be),
        .we_n(pin_we_n),
        .rd_n(pin_rd_n),
        .rw_dir(pin_rw_dir)
    );

    always_comb begin
        logic [AREA_W:0] s;
        logic [3:0] wait_cyc;
        logic active;
        n = r;
        s = '0;
        wait_cyc = 4'h0;
        active = 1'b0;
        n.rsp_valid = 1'b0;
        n.hready = 1'b1;

        // Data phase of a register write
        if (r.dp_wr) begin
            s = slot(r.dp_addr, `EW_WCR_BASE);
            if (s[AREA_W]) begin
                // Layout taken from the bus control already in place
                n.wcr[s[AREA_W-1:0]] = hwdata & wcr_mask(r.bcr[s[AREA_W-1:0]]);
            end
            s = slot(r.dp_addr, `EW_BCR_BASE);
            if (s[AREA_W]) begin
                n.bcr[s[AREA_W-1:0]] = hwdata & `EW_BCR_MASK;
            end
        end
        n.dp_wr = 1'b0;

        // Address phase; reads see a write in flight because n already holds it
        if (hsel && htrans[`EW_HTRANS_ACT_BIT] && hready) begin
            n.dp_wr = hwrite;
            n.dp_addr = haddr[`EW_DEC_W-1:0];
            if (!hwrite) begin
                n.hrdata = 32'h0000_0000;
                s = slot(haddr[`EW_DEC_W-1:0], `EW_WCR_BASE);
                if (s[AREA_W]) begin
                    n.hrdata = n.wcr[s[AREA_W-1:0]] & wcr_mask(n.bcr[s[AREA_W-1:0]]);
                end
                s = slot(haddr[`EW_DEC_W-1:0], `EW_BCR_BASE);
                if (s[AREA_W]) begin
                    n.hrdata = n.bcr[s[AREA_W-1:0]];
                end
                if (haddr[`EW_DEC_W-1:0] == `EW_STAT_OFF) begin
                    n.hrdata = {16'h0000, r.elapsed, 1'b0, r.prev_kind, 5'h00, r.st};
                end
            end
        end

        // Access engine
        unique case (r.st)
            ST_IDLE: begin
                if (req_valid && r.req_ready) begin
                    n.req_ready = 1'b0;
                    n.cur_kind = kind_of(r.bcr[area_sel], r.wcr[area_sel]);
                    n.cur_write = req_write;
                    n.cur_area = area_sel;
                    n.cur_be = req_be;
                    n.cur_addr = req_addr;
                    n.cur_wdata = req_wdata;
                    // Idle cycles already spent count toward the need, except from a quiet bus
                    if (r.prev_kind == K_NONE) begin
                        wait_cyc = idle_need;
                    end else if (idle_need > r.elapsed) begin
                        wait_cyc = idle_need - r.elapsed;
                    end
                    n.cnt = wait_cyc;
                    n.st = (wait_cyc == 4'h0) ? ST_SETUP : ST_GAP;
                end else begin
                    n.req_ready = 1'b1;
                    if (r.elapsed == `EW_IDLE_FORGET) begin
                        n.prev_kind = K_NONE;
                    end else begin
                        n.elapsed = r.elapsed + 4'h1;
                    end
                end
            end
            ST_GAP: begin
                n.cnt = r.cnt - 4'h1;
                if (r.cnt == 4'h1) begin
                    n.st = ST_SETUP;
                end
            end
            ST_SETUP: begin
                n.st = ST_STROBE;
                n.cnt = r.cur_write ? {1'b0, r.wcr[r.cur_area][`EW_WCR_WRITE_WAIT_LSB +: 3]}
                                    : r.wcr[r.cur_area][`EW_WCR_WR_LSB +: 4];
            end
            ST_STROBE: begin
                if (r.cnt == 4'h0) begin
                    n.st = ST_HOLD;
                end else begin
                    n.cnt = r.cnt - 4'h1;
                end
            end
            ST_HOLD: begin
                // Pins lag state by one cycle, so the last strobe cycle is on the pins now
                n.rsp_rdata = r.cur_write ? 32'h0000_0000 : ext_data_in;
                n.rsp_valid = 1'b1;
                n.req_ready = 1'b1;
                n.prev_kind = r.cur_kind;
                n.prev_write = r.cur_write;
                n.prev_area = r.cur_area;
                n.elapsed = 4'h1;
                n.st = ST_IDLE;
            end
        endcase

        // Pins registered from the current phase
        active = (r.st == ST_SETUP) || (r.st == ST_STROBE) || (r.st == ST_HOLD);
        n.cs_n = '1;
        if (active) begin
            n.cs_n[r.cur_area] = 1'b0;
        end
        n.addr_o = active ? r.cur_addr : r.addr_o;
        n.rd_n = pin_rd_n;
        n.we_n = pin_we_n;
        n.rw_dir = pin_rw_dir;
        n.dout = r.cur_wdata;
        n.doe = active && r.cur_write;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r <= RST_V;
        end else begin
            r <= n;
        end
    end

    assign hreadyout = r.hready;
    assign hresp = 1'b0;
    assign hrdata = r.hrdata;
    assign req_ready = r.req_ready;
    assign rsp_valid = r.rsp_valid;
    assign rsp_rdata = r.rsp_rdata;
    assign ext_cs_n = r.cs_n;
    assign ext_addr = r.addr_o;
    assign ext_rd_n = r.rd_n;
    assign byte_write_strobe_n = r.we_n;
    assign read_write_direction = r.rw_dir;
    assign ext_data_out = r.dout;
    assign ext_data_oe = r.doe;

endmodule // ewic_top

/* File: dv/ewic_monitor.sv */
// Port-level assertions for the wait and idle-cycle controller
`timescale 1ns/1ps
module ewic_monitor #(
    parameter int NUM_AREAS = 9
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Access handshake
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic rsp_valid,
    // External pins
    input wire logic [NUM_AREAS-1:0] ext_cs_n,
    input wire logic ext_rd_n,
    input wire logic [3:0] byte_write_strobe_n,
    input wire logic read_write_direction,
    input wire logic ext_data_oe
);
    logic rd_wcr_reg;
    logic cs_act;
    assign cs_act = ext_cs_n != '1;
    // Marks the data phase of a read in the wait control block
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) rd_wcr_reg <= 1'b0;
        else rd_wcr_reg <= hsel && htrans[1] && hready && !hwrite && haddr < 32'h0000_0040;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_take;
        req_valid && req_ready;
    endsequence
    sequence s_serve;
        !req_ready ##[3:60] rsp_valid;
    endsequence
    a_take_serve: assert property (s_take |=> s_serve) else $error("access not answered");
    a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid) else $error("rsp_valid too long");
    a_rsp_ready: assert property (rsp_valid |-> req_ready) else $error("ready late");
    a_end_idle: assert property (rsp_valid |=> !cs_act) else $error("no idle cycle");
    a_bus_okay: assert property (hresp == 1'b0 && hreadyout) else $error("bus answer wrong");
    a_strobe_cs: assert property (byte_write_strobe_n != 4'hF |-> cs_act) else $error("strobe");
    a_dir_cs: assert property (read_write_direction |-> cs_act) else $error("dir outside");
    a_read_quiet: assert property (!ext_rd_n |-> !ext_data_oe && !read_write_direction)
        else $error("drive in read");
    a_one_cs: assert property ($onehot0(~ext_cs_n)) else $error("two selects");
    a_wcr_rsvd: assert property (rd_wcr_reg |-> hrdata[31:21] == 11'h000 && !hrdata[19])
        else $error("reserved bits set");
endmodule // ewic_monitor

bind ewic_top ewic_monitor #(.NUM_AREAS(NUM_AREAS)) u_mon (.clk(clk), .nrst(nrst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .req_valid(req_valid), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .ext_cs_n(ext_cs_n), .ext_rd_n(ext_rd_n),
    .byte_write_strobe_n(byte_write_strobe_n), .read_write_direction(read_write_direction),
    .ext_data_oe(ext_data_oe));

/* File: dv/ewic_mem_model.sv */
// Behavioural external memory answering on the controller's pins
`timescale 1ns/1ps
module ewic_mem_model #(
    parameter int NUM_AREAS = 9,
    parameter int ADDR_W = 24
) (
    // Clock
    input wire logic clk,
    // Controller pins
    input wire logic [NUM_AREAS-1:0] ext_cs_n,
    input wire logic [ADDR_W-1:0] ext_addr,
    input wire logic ext_rd_n,
    input wire logic [3:0] byte_write_strobe_n,
    input wire logic [31:0] ext_data_out,
    input wire logic ext_data_oe,
    // Read data
    output logic [31:0] ext_data_in
);
    logic [31:0] mem [16];
    logic [31:0] last = 32'h0000_0000;
    logic sel;
    assign sel = ext_cs_n != '1;
    initial for (int i = 0; i < 16; i++) mem[i] = 32'h0000_0000;
    // Released bus toggles so a late sample cannot hit the old word
    assign ext_data_in = (sel && !ext_rd_n) ? mem[ext_addr[3:0]] : ~last;
    always @(posedge clk) begin
        last <= ext_data_in;
        for (int i = 0; i < 4; i++)
            if (sel && ext_data_oe && !byte_write_strobe_n[i])
                mem[ext_addr[3:0]][8*i+:8] <= ext_data_out[8*i+:8];
    end
endmodule // ewic_mem_model

/* File: dv/ext_bus_wait_idle_control_test.sv */
// Self-checking bench for the wait and idle-cycle controller
`timescale 1ns/1ps
module ext_bus_wait_idle_control_test;
    typedef struct {int take; int wt; int s; int ty; logic w; logic [31:0] rd;} ewic_note_t;
    localparam int S_WRITE = 1;
    localparam int S_READ = 2;
    ewic_note_t q[$];
    logic clk, nrst, hsel, hwrite, hready, hreadyout, hresp, req_valid, req_write, req_ready;
    logic rsp_valid, ext_rd_n, read_write_direction, ext_data_oe, seen;
    logic [31:0] haddr, hwdata, hrdata, req_wdata, rsp_rdata, ext_data_in, ext_data_out;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] req_area, req_be, byte_write_strobe_n;
    logic [23:0] req_addr, ext_addr;
    logic [8:0] ext_cs_n;
    logic [31:0] mirror [16];
    int n_errors = 0, num_checks = 0, cyc = 0, seed = 42550, first_cs = 0, nwe = 0, ndir = 0;
    assign hready = hreadyout;

    ewic_top u_dut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .req_valid(req_valid),
        .req_area(req_area), .req_addr(req_addr), .req_write(req_write), .req_be(req_be),
        .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .ext_cs_n(ext_cs_n), .ext_addr(ext_addr), .ext_rd_n(ext_rd_n),
        .byte_write_strobe_n(byte_write_strobe_n), .read_write_direction(read_write_direction),
        .ext_data_in(ext_data_in), .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe));
    ewic_mem_model u_mem (.clk(clk), .ext_cs_n(ext_cs_n), .ext_addr(ext_addr),
        .ext_rd_n(ext_rd_n), .byte_write_strobe_n(byte_write_strobe_n),
        .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe), .ext_data_in(ext_data_in));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic end_of_test();
        if (n_errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %0t word %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk_count(input int g, input int e);
        num_checks++;
        if (g != e) begin
            n_errors++;
            $display("CHECK FAILED %0t count %0d expected %0d", $time, g, e);
        end
    endtask

    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0000_0000, r);
        chk_word(r, e);
    endtask

    // Leaves req_valid up so the next call is back to back
    task automatic acc(input int area, input logic w, input logic [3:0] be, input int wt,
                       input int ty);
        ewic_note_t n;
        logic [3:0] a;
        logic [31:0] d;
        a = 4'($random(seed));
        d = $random(seed);
        req_valid <= 1'b1;
        req_area <= 4'(area);
        req_addr <= {20'h0_0000, a};
        req_write <= w;
        req_be <= be;
        req_wdata <= d;
        do @(posedge clk); while (req_ready !== 1'b1);
        n.take = cyc;
        n.wt = wt;
        n.ty = ty;
        n.w = w;
        n.s = w ? S_WRITE : S_READ;
        n.rd = w ? 32'h0000_0000 : mirror[a];
        for (int i = 0; i < 4; i++) if (w && be[i]) mirror[a][8*i+:8] = d[8*i+:8];
        q.push_back(n);
    endtask

    task automatic idle(input int n);
        req_valid <= 1'b0;
        repeat (n) @(posedge clk);
    endtask

    always @(posedge clk) cyc <= cyc + 1;
    always @(posedge clk) if (cyc > 20000) begin
        n_errors++;
        end_of_test();
    end

    always @(posedge clk) begin
        ewic_note_t n;
        if (nrst === 1'b1 && ext_cs_n !== 9'h1FF) begin
            if (!seen) first_cs = cyc;
            seen = 1'b1;
            nwe += int'(byte_write_strobe_n !== 4'hF);
            ndir += int'(read_write_direction === 1'b1);
        end
        if (nrst === 1'b1 && rsp_valid === 1'b1) begin
            if (q.size() == 0) chk_count(0, 1);
            else begin
                n = q.pop_front();
                chk_word(rsp_rdata, n.rd);
                chk_count(first_cs - n.take, n.wt + 2);
                if (n.ty < 3) begin
                    chk_count(cyc - n.take, n.wt + n.s + 4);
                    chk_count(nwe, n.ty == 2 ? n.s + 3 : (n.ty == 1 || n.w) ? n.s + 1 : 0);
                    chk_count(ndir, !n.w ? 0 : n.ty == 2 ? n.s + 1 : n.s + 3);
                end
            end
            seen = 1'b0;
            nwe = 0;
            ndir = 0;
        end
    end

    initial begin
        {hsel, hwrite, req_valid, req_write, seen, nrst} = '0;
        {haddr, hwdata, req_wdata, req_addr, req_area, req_be, htrans} = '0;
        hsize = 3'b010;
        for (int i = 0; i < 16; i++) mirror[i] = 32'h0000_0000;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd_chk(32'h0000_0000, 32'h0000_0500);
        rd_chk(32'h0000_0040, 32'h0022_2220);
        wr(32'h0000_0000, 32'hFFFF_FFFF);
        rd_chk(32'h0000_0000, 32'h0017_1FC3);
        rd_chk(32'h0000_00C0, 32'h0000_0000);
        // Bus control before wait control, idle fields cleared
        for (int i = 0; i < 4; i++) wr(32'h0000_0040 + 4 * i, i);
        wr(32'h0000_0000, 32'h0001_0140);
        wr(32'h0000_0008, 32'hFFFF_FFFF);
        rd_chk(32'h0000_0008, 32'h0000_03FF);
        acc(3, 1'b0, 4'hF, 2, 3);
        idle(12);
        for (int b = 0; b < 3; b++) begin
            wr(32'h0000_0004, b == 2 ? 32'h0011_0140 : 32'h0001_0140);
            acc(b > 0, 1'b1, 4'h3, 0, b);
            acc(b > 0, 1'b0, 4'hF, 0, b);
            idle(12);
        end
        wr(32'h0000_0048, 32'h0000_0012);
        wr(32'h0000_0040, 32'h0040_0020);
        acc(0, 1'b0, 4'hF, 0, 0);
        acc(0, 1'b0, 4'hF, 3, 0);
        acc(0, 1'b1, 4'hF, 0, 0);
        acc(0, 1'b1, 4'hC, 1, 0);
        acc(2, 1'b1, 4'hF, 1, 3);
        acc(3, 1'b1, 4'hF, 1, 3);
        acc(2, 1'b0, 4'hF, 0, 3);
        acc(3, 1'b0, 4'hF, 0, 3);
        acc(2, 1'b1, 4'hF, 0, 3);
        acc(0, 1'b0, 4'hF, 0, 0);
        idle(12);
        end_of_test();
    end
endmodule // ext_bus_wait_idle_control_test
